// ### rtl/suem_regs.vh
// register offsets, fields, reset values and write masks for the secondary error mask block
`ifndef SUEM_REGS_VH
`define SUEM_REGS_VH

`define SUEM_MASK_OFFSET      12'h130
`define SUEM_SEVERITY_OFFSET  12'h134
`define SUEM_STATUS_OFFSET    12'h12C
`define SUEM_MASK_RESET       32'h000017A8
`define SUEM_SEVERITY_RESET   32'h00001340
// functional classes: bits 12,11,10,9,7,3,2
`define SUEM_FUNC_BITS        32'h00001E8C
// storage-only bits: 13,8,6,5,1
`define SUEM_STORE_BITS       32'h00002162
`define SUEM_WRITE_BITS       32'h00003FEE
`define SUEM_PTR_WIDTH        5
`define SUEM_HDR_WIDTH        128

`endif

// ### rtl/suem_log_store.v
// capture register for the secondary header log words
`timescale 1ns/10ps
`default_nettype none

module suem_log_store #(
   parameter WIDTH = 128
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             load,
   input  wire [WIDTH-1:0] load_data,
   output reg  [WIDTH-1:0] log_data
);

   always @(posedge clk) begin
      if (reset) begin
         log_data <= {WIDTH{1'b0}};
      end else if (load) begin
         log_data <= load_data;
      end
   end

endmodule

`default_nettype wire

// ### rtl/suem_top.v
// secondary uncorrectable error mask and severity registers with reporting gate
//
// What this block does
// R01 - masked error class leaves its status bit unchanged
// R02 - masked error class sends no error message upstream
// R03 - masked error class does not load the secondary header log
// R04 - masked error class leaves the first fault pointer unchanged
// R05 - mask bit zero enables status, message, log and pointer update
// R06 - mask register at offset 130h, reset value 0000 17A8h
// R07 - unmasked error is fatal when severity bit is 1, else nonfatal
// R08 - severity register at offset 134h, reset value 0000 1340h
// R09 - functional bits 12,11,10,9,7,3,2, one per error class
// R10 - bits 31:14 and bit 4 reserved, read zero
// R11 - bits 13,8,6,5,1 plain storage; bit 0 read-only zero
// R12 - fundamental, global or power-on reset restores defaults
// R13 - status bits set by hardware, cleared by writing 1b
// R14 - five-bit first fault pointer records first unmasked error position
// R15 - writes to reserved or read-only bits are ignored
// R16 - lookups use register contents of the detection cycle
`timescale 1ns/10ps
`default_nettype none
`include "suem_regs.vh"

module suem_top (
   input  wire         clk,
   input  wire         reset,
   input  wire         fundamental_reset,
   input  wire         global_reset_input,
   input  wire         cfg_write,
   input  wire         cfg_read,
   input  wire [11:0]  cfg_addr,
   input  wire [31:0]  cfg_wdata,
   input  wire [3:0]   cfg_byte_en,
   input  wire [31:0]  error_detect,
   input  wire [127:0] error_header,
   output reg  [31:0]  cfg_rdata,
   output reg          cfg_ack,
   output reg  [31:0]  error_status,
   output reg  [4:0]   secondary_first_fault_pointer,
   output reg          err_fatal_msg,
   output reg          err_nonfatal_msg,
   output wire [127:0] header_log
);

   // -----------------------------------------------------------------
   // reset sources and synchronisers for the global and fundamental reset pins
   // -----------------------------------------------------------------
   reg         global_reset_input_meta_reg;
   reg         global_reset_input_sync_reg;
   reg         perst_meta_reg;
   reg         perst_sync_reg;
   wire        any_reset;

   always @(posedge clk) begin
      global_reset_input_meta_reg  <= global_reset_input;
      global_reset_input_sync_reg  <= global_reset_input_meta_reg;
      perst_meta_reg <= fundamental_reset;
      perst_sync_reg <= perst_meta_reg;
   end

   // pins reach logic only through the second synchroniser flop
   assign any_reset = reset | global_reset_input_sync_reg | perst_sync_reg; // [R12]

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   reg  [31:0] mask_reg;
   reg  [31:0] severity_reg;
   wire [31:0] mask_next;
   wire [31:0] severity_next;
   wire [31:0] be_mask;
   wire        hit_mask;
   wire        hit_sev;
   wire        hit_status;
   wire [31:0] wr_keep;

   assign be_mask    = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                        {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
   assign hit_mask   = (cfg_addr == `SUEM_MASK_OFFSET);        // [R06]
   assign hit_sev    = (cfg_addr == `SUEM_SEVERITY_OFFSET);    // [R08]
   assign hit_status = (cfg_addr == `SUEM_STATUS_OFFSET);
   assign wr_keep    = be_mask & `SUEM_WRITE_BITS;             // [R15]

   // reserved and read-only bits never change
   assign mask_next     = (mask_reg & ~wr_keep) | (cfg_wdata & wr_keep);     // [R10] [R11] [R15]
   assign severity_next = (severity_reg & ~wr_keep) | (cfg_wdata & wr_keep); // [R11] [R15]

   always @(posedge clk) begin
      if (any_reset) begin
         mask_reg     <= `SUEM_MASK_RESET;      // [R06] [R12]
         severity_reg <= `SUEM_SEVERITY_RESET;  // [R08] [R12]
      end else if (cfg_write) begin
         if (hit_mask) begin
            mask_reg <= mask_next;
         end
         if (hit_sev) begin
            severity_reg <= severity_next;
         end
      end
   end

   // -----------------------------------------------------------------
   // error gating with the current mask
   // -----------------------------------------------------------------
   wire [31:0] live_err;
   wire        any_live;

   // only functional classes report; masked classes are dropped here
   assign live_err = error_detect & `SUEM_FUNC_BITS & ~mask_reg; // [R01] [R05] [R09] [R16]
   assign any_live = |live_err;

   // -----------------------------------------------------------------
   // lowest-numbered unmasked class, one stage per status bit
   // -----------------------------------------------------------------
   wire [32:0] lower_seen;
   wire [31:0] first_hot;
   wire [4:0]  first_pos;
   wire        found;
   genvar      j;

   assign lower_seen[0] = 1'b0;

   generate
      for (j = 0; j < 32; j = j + 1) begin : g_first
         assign first_hot[j]    = live_err[j] & ~lower_seen[j]; // [R14]
         assign lower_seen[j+1] = lower_seen[j] | live_err[j];
      end
   endgenerate

   // one-hot to binary, each pointer bit ors a fixed column of positions
   assign first_pos[4] = |(first_hot & 32'hFFFF0000);
   assign first_pos[3] = |(first_hot & 32'hFF00FF00);
   assign first_pos[2] = |(first_hot & 32'hF0F0F0F0);
   assign first_pos[1] = |(first_hot & 32'hCCCCCCCC);
   assign first_pos[0] = |(first_hot & 32'hAAAAAAAA);
   assign found        = lower_seen[32];

   // -----------------------------------------------------------------
   // status and first fault pointer
   // -----------------------------------------------------------------
   wire [31:0] clr_bits;
   wire [31:0] status_kept;
   wire        status_empty;
   reg         ptr_valid_reg;

   assign clr_bits     = (cfg_write && hit_status) ? (cfg_wdata & be_mask) : 32'h00000000;
   assign status_kept  = error_status & ~clr_bits;
   assign status_empty = (status_kept == 32'h00000000);

   always @(posedge clk) begin
      if (any_reset) begin
         error_status                  <= 32'h00000000;
         secondary_first_fault_pointer <= 5'h00;
         ptr_valid_reg                 <= 1'b0;
      end else begin
         // set wins over a simultaneous write-one clear
         error_status <= status_kept | live_err; // [R01] [R13]
         // pointer rearms only once every status bit has been cleared
         if (found && (!ptr_valid_reg || status_empty)) begin
            secondary_first_fault_pointer <= first_pos; // [R04] [R14]
            ptr_valid_reg                 <= 1'b1;
         end else if (status_empty) begin
            ptr_valid_reg <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // upstream error messages
   // -----------------------------------------------------------------
   wire [31:0] fatal_hit;
   wire [31:0] nonfatal_hit;

   // severity is taken in the detection cycle, like the mask
   assign fatal_hit    = live_err & severity_reg;  // [R07] [R16]
   assign nonfatal_hit = live_err & ~severity_reg; // [R07] [R16]

   always @(posedge clk) begin
      if (any_reset) begin
         err_fatal_msg    <= 1'b0;
         err_nonfatal_msg <= 1'b0;
      end else begin
         err_fatal_msg    <= |fatal_hit;    // [R02] [R07]
         err_nonfatal_msg <= |nonfatal_hit; // [R02] [R07]
      end
   end

   // -----------------------------------------------------------------
   // header log capture
   // -----------------------------------------------------------------
   suem_log_store #(
      .WIDTH     (`SUEM_HDR_WIDTH)
   ) u_log (
      .clk       (clk),
      .reset     (any_reset),
      .load      (any_live),      // [R03] [R05]
      .load_data (error_header),
      .log_data  (header_log)
   );

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (any_reset) begin
         cfg_rdata <= 32'h00000000;
         cfg_ack   <= 1'b0;
      end else begin
         cfg_ack <= cfg_read | cfg_write;
         // reads have no side effects; unmapped offsets return zero
         if (cfg_read && hit_mask) begin
            cfg_rdata <= mask_reg & `SUEM_WRITE_BITS;      // [R10]
         end else if (cfg_read && hit_sev) begin
            cfg_rdata <= severity_reg & `SUEM_WRITE_BITS;  // [R10]
         end else if (cfg_read && hit_status) begin
            cfg_rdata <= error_status;
         end else begin
            cfg_rdata <= 32'h00000000;
         end
      end
   end

endmodule

`default_nettype wire

// ### testbench/suem_upstream.sv
// upstream port model that tallies received error messages
`timescale 1ns/10ps
`default_nettype none
module suem_upstream (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       fatal_msg,
   input  wire logic       nonfatal_msg,
   output var  logic [7:0] fatal_cnt,
   output var  logic [7:0] nonfatal_cnt
);
   always @(posedge clk) begin
      if (reset) begin
         fatal_cnt <= 8'h00;
         nonfatal_cnt <= 8'h00;
      end else begin
         fatal_cnt <= fatal_cnt + {7'h00, fatal_msg};
         nonfatal_cnt <= nonfatal_cnt + {7'h00, nonfatal_msg};
      end
   end
endmodule
`default_nettype wire

// ### testbench/suem_chk.sv
// port assertions for the mask and severity block
`timescale 1ns/10ps
`default_nettype none
`include "suem_regs.vh"
module suem_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        fundamental_reset,
   input wire logic        global_reset_input,
   input wire logic        cfg_write,
   input wire logic        cfg_read,
   input wire logic        cfg_ack,
   input wire logic [31:0] error_detect,
   input wire logic [31:0] error_status,
   input wire logic [4:0]  secondary_first_fault_pointer,
   input wire logic        err_fatal_msg,
   input wire logic        err_nonfatal_msg
);
   localparam logic [31:0] F = `SUEM_FUNC_BITS;
   default clocking @(posedge clk); endclocking
   default disable iff (reset || fundamental_reset || global_reset_input);
   ack_follow_a: assert property ((cfg_write || cfg_read) |=> cfg_ack)
      else $error("missing ack");
   ack_only_a: assert property (!(cfg_write || cfg_read) |=> !cfg_ack)
      else $error("stray ack");
   no_msg_a: assert property (!(|(error_detect & F))
      |=> !(err_fatal_msg || err_nonfatal_msg)) else $error("stray message");
   stat_set_a: assert property ((|(error_detect & F)) ##1 err_fatal_msg
      |-> (error_status & $past(error_detect)) != 32'h0) else $error("status not set");
   stat_idle_a: assert property (!cfg_write && !(|(error_detect & F))
      |=> $stable(error_status)) else $error("status moved");
   stat_rsvd_a: assert property ((error_status & ~F) == 32'h0)
      else $error("bad status bit");
   ptr_first_a: assert property ($rose(|error_status)
      |-> error_status[secondary_first_fault_pointer]) else $error("bad pointer");
   ptr_hold_a: assert property ((|error_status) ##1 (|error_status)
      |-> $stable(secondary_first_fault_pointer)) else $error("pointer moved");
   cover property (err_fatal_msg);
   cover property (err_nonfatal_msg);
   cover property ($rose(|error_status));
endmodule
bind suem_top suem_chk u_chk (.*);
`default_nettype wire

// ### testbench/suem_tb_top.sv
// self-checking testbench for the mask and severity block
`timescale 1ns/10ps
`default_nettype none
module suem_tb_top;
   logic         clk = 1'h0, reset = 1'h1, fundamental_reset = 1'h0;
   logic         global_reset_input = 1'h0, cfg_write = 1'h0, cfg_read = 1'h0;
   logic         cfg_ack, err_fatal_msg, err_nonfatal_msg;
   logic [11:0]  cfg_addr = 12'h000;
   logic [3:0]   cfg_byte_en = 4'hF;
   logic [31:0]  cfg_wdata = 32'h0, error_detect = 32'h0, cfg_rdata, error_status;
   logic [127:0] error_header = 128'h0, header_log, log_exp = 128'h0;
   logic [4:0]   secondary_first_fault_pointer, p_exp = 5'h00;
   logic [7:0]   fatal_cnt, nonfatal_cnt, f_exp = 8'h00, nf_exp = 8'h01;
   logic [38:0]  tbl [0:8];
   int           err_count = 0, n_checks = 0;
   always #20 clk = ~clk;
   suem_top u_dut (.clk(clk), .reset(reset), .fundamental_reset(fundamental_reset),
      .global_reset_input(global_reset_input), .cfg_write(cfg_write), .cfg_read(cfg_read),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_byte_en(cfg_byte_en),
      .error_detect(error_detect), .error_header(error_header), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .error_status(error_status),
      .secondary_first_fault_pointer(secondary_first_fault_pointer),
      .err_fatal_msg(err_fatal_msg), .err_nonfatal_msg(err_nonfatal_msg),
      .header_log(header_log));
   suem_upstream u_up (.clk(clk), .reset(reset), .fatal_msg(err_fatal_msg),
      .nonfatal_msg(err_nonfatal_msg), .fatal_cnt(fatal_cnt), .nonfatal_cnt(nonfatal_cnt));
   task chk(input [127:0] got, input [127:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task acc(input w, input [11:0] a, input [31:0] d, input [3:0] be);
      @(posedge clk);
      cfg_write <= w;
      cfg_read <= !w;
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_byte_en <= be;
      @(posedge clk);
      cfg_write <= 1'h0;
      cfg_read <= 1'h0;
      @(negedge clk);
   endtask
   task pulse(input [31:0] e, input [127:0] h);
      @(posedge clk);
      error_detect <= e;
      error_header <= h;
      cfg_write <= e[11];
      @(posedge clk);
      error_detect <= 32'h0;
      cfg_write <= 1'h0;
      @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      end_of_test;
   end
   initial begin
      tbl = '{{16'h0,16'h1000,5'hC,2'h2}, {16'h0,16'h0,5'hB,2'h1}, {16'h0,16'h400,5'hA,2'h2},
         {16'h0,16'h0,5'h9,2'h1}, {16'h0,16'h80,5'h7,2'h2}, {16'h0,16'h0,5'h3,2'h1},
         {16'h0,16'h4,5'h2,2'h2}, {16'h1E8C,16'h1E8C,5'hC,2'h0}, {16'h2162,16'h80,5'h7,2'h2}};
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      acc(1'h0, 12'h130, 32'h0, 4'hF);
      chk(cfg_rdata, 32'h17A8);
      acc(1'h0, 12'h134, 32'h0, 4'hF);
      chk(cfg_rdata, 32'h1340);
      @(posedge clk);
      cfg_addr <= 12'h130;
      cfg_wdata <= 32'hFFFFFFFF;
      pulse(32'h800, 128'h0);
      chk(nonfatal_cnt, nf_exp);
      chk(error_status, 32'h800);
      for (int i = 0; i < 9; i++) begin
         acc(1'h1, 12'h130, {16'h0, tbl[i][38:23]}, 4'hF);
         acc(1'h1, 12'h134, {16'h0, tbl[i][22:7]}, 4'hF);
         acc(1'h1, 12'h12C, 32'hFFFFFFFF, 4'hF);
         pulse(32'h1 << tbl[i][6:2], {32{i[3:0]}});
         f_exp = f_exp + {7'h0, tbl[i][1]};
         nf_exp = nf_exp + {7'h0, tbl[i][0]};
         chk(fatal_cnt, f_exp);
         chk(nonfatal_cnt, nf_exp);
         chk(error_status, (|tbl[i][1:0]) ? 32'h1 << tbl[i][6:2] : 32'h0);
         if (|tbl[i][1:0]) log_exp = {32{i[3:0]}};
         chk(header_log, log_exp);
         if (|tbl[i][1:0]) p_exp = tbl[i][6:2];
         chk(secondary_first_fault_pointer, p_exp);
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         fundamental_reset <= (k == 0);
         global_reset_input <= (k == 1);
         repeat (4) @(posedge clk);
         fundamental_reset <= 1'h0;
         global_reset_input <= 1'h0;
         repeat (4) @(posedge clk);
         acc(1'h0, 12'h130, 32'h0, 4'hF);
         chk(cfg_rdata, 32'h17A8);
         acc(1'h0, 12'h134, 32'h0, 4'hF);
         chk(cfg_rdata, 32'h1340);
         chk(error_status, 32'h0);
         chk(header_log, 128'h0);
      end
      pulse(32'h4, 128'h5);
      pulse(32'h800, 128'h9);
      nf_exp = nf_exp + 8'h02;
      chk(nonfatal_cnt, nf_exp);
      chk(secondary_first_fault_pointer, 5'h02);
      chk(header_log, 128'h9);
      acc(1'h0, 12'h12C, 32'h0, 4'hF);
      chk(cfg_rdata, 32'h804);
      acc(1'h1, 12'h12C, 32'h4, 4'hF);
      chk(error_status, 32'h800);
      chk(secondary_first_fault_pointer, 5'h02);
      acc(1'h1, 12'h134, 32'hFFFFFFFF, 4'hF);
      acc(1'h0, 12'h134, 32'h0, 4'hF);
      chk(cfg_rdata, 32'h3FEE);
      acc(1'h1, 12'h134, 32'h0, 4'h2);
      acc(1'h0, 12'h134, 32'h0, 4'hF);
      chk(cfg_rdata, 32'hEE);
      acc(1'h0, 12'h200, 32'h0, 4'hF);
      chk(cfg_rdata, 32'h0);
      end_of_test;
   end
endmodule
`default_nettype wire
